// *** inc/adcs_pkg.sv ***
// Purpose: shared constants for the converter sequencer
// Assumes: 40 MHz core clock, 16-bit internal register port
// Notes:   item index 0..5 = measurement 1, 2, diag slot 0..3

package adcs_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  ADDR_CONV_CTRL = 8'h3b;
  localparam logic [7:0]  ADDR_DIAG_SEL  = 8'h3c;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] DSEL_RESET     = 16'h0000;
  localparam logic [15:0] CTRL_WMASK     = 16'hff03;
  localparam logic [15:0] DSEL_WMASK     = 16'hffff;

  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int RATE_LSB    = 14;
  localparam int MODE_LSB    = 12;
  localparam int DIAG_EN_LSB = 8;
  localparam int MEAS2_BIT   = 1;
  localparam int MEAS1_BIT   = 0;

  // ---------------------------------------------------------------
  // codes
  // ---------------------------------------------------------------
  localparam logic [1:0] RATE_SLOW = 2'h0;
  localparam logic [1:0] RATE_4K8  = 2'h1;
  localparam logic [1:0] RATE_9K6  = 2'h2;

  localparam logic [1:0] MODE_STANDBY    = 2'h0;
  localparam logic [1:0] MODE_SINGLE     = 2'h1;
  localparam logic [1:0] MODE_CONTINUOUS = 2'h2;
  localparam logic [1:0] MODE_POWERDOWN  = 2'h3;

  localparam logic [3:0] SRC_ANALOG_GROUND_ALT = 4'he;
  localparam logic [3:0] SRC_CURRENT  = 4'hf;

  localparam logic [4:0] ROUTE_ANALOG_GROUND = 5'h00;
  localparam logic [4:0] ROUTE_INT_SOURCE    = 5'h10;
  localparam logic [4:0] ROUTE_INT_SINK      = 5'h11;
  localparam logic [4:0] ROUTE_EXT_SOURCE    = 5'h12;
  localparam logic [4:0] ROUTE_EXT_SINK      = 5'h13;
  localparam logic [4:0] ROUTE_MEASUREMENT   = 5'h1f;

  localparam logic [2:0] ITEM_FIRST_DIAG = 3'h2;
  localparam logic [2:0] ITEM_NONE       = 3'h6;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 25;
  localparam int POWERUP_NS     = 100000;
  localparam int POWERUP_CYCLES =
    (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// *** src/adcs_powerup_timer.sv ***
// Purpose: converter power-up wait counter
// Assumes: start_i is a one-cycle pulse
// Notes:   done_o pulses POWERUP_CYCLES + 1 cycles after start_i

`timescale 1ns/1ps

module adcs_powerup_timer (
  input  wire logic mclk_i,    // core clock
  input  wire logic resetn_i,  // sync reset, active low
  input  wire logic start_i,   // begin power-up wait
  output logic      busy_o,    // wait in progress
  output logic      done_o     // wait over, one cycle
);

  typedef struct packed {
    logic [11:0] count;
    logic        run;
    logic        done;
  } adcs_timer_type;

  adcs_timer_type t_reg;
  adcs_timer_type t_next;

  always_comb begin
    t_next      = t_reg;
    t_next.done = 1'b0;
    if (start_i) begin
      t_next.count = 12'(adcs_pkg::POWERUP_CYCLES - 1);
      t_next.run   = 1'b1;
    end else if (t_reg.run) begin
      if (t_reg.count == 12'h000) begin
        t_next.run  = 1'b0;
        t_next.done = 1'b1;
      end else begin
        t_next.count = t_reg.count - 12'h001;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end

  assign busy_o = t_reg.run;
  assign done_o = t_reg.done;

  a_timer_load: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    start_i |=> t_reg.run &&
      t_reg.count == 12'(adcs_pkg::POWERUP_CYCLES - 1))
    else $error("power-up timer not loaded");

  a_timer_done: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    done_o |-> $past(t_reg.run) && $past(t_reg.count) == 12'h000
      && !t_reg.run)
    else $error("power-up done without full count");

endmodule

// *** src/adcs_sequencer.sv ***
// Purpose: converter sequencer with control and source-select registers
// Assumes: host keeps converter idle while changing control register
// Notes:   conv_done_i comes from the converter datapath on mclk_i

`timescale 1ns/1ps

module adcs_sequencer (
  input  wire logic        mclk_i,        // core clock, 40 MHz
  input  wire logic        resetn_i,      // sync reset, active low
  input  wire logic [7:0]  reg_addr_i,    // register address
  input  wire logic        reg_wr_i,      // write strobe
  input  wire logic [15:0] reg_wdata_i,   // write data
  input  wire logic        reg_rd_i,      // read strobe
  output logic      [15:0] reg_rdata_o,   // read data, next cycle
  input  wire logic        conv_done_i,   // conversion finished
  output logic             conv_start_o,  // start one conversion
  output logic      [2:0]  conv_item_o,   // item being converted
  output logic      [4:0]  diag_route_o,  // source for the item
  output logic      [1:0]  diag_rate_o,   // effective diag rate
  output logic             adc_powered_o, // converter powered
  output logic             adc_busy_o     // live busy flag
);

  typedef enum logic [1:0] {
    ST_OFF,
    ST_PWRUP,
    ST_IDLE,
    ST_WAIT
  } adcs_seq_type;

  typedef struct packed {
    adcs_seq_type st;
    logic [15:0]  ctrl;
    logic [15:0]  dsel;
    logic [15:0]  rdata;
    logic [2:0]   item;
    logic [4:0]   route;
    logic         go;
    logic         start;
    logic         powered;
    logic         timer_start;
  } adcs_state_type;

  adcs_state_type s_reg;
  adcs_state_type s_next;

  logic       tmr_done;
  logic       tmr_busy;
  logic [1:0] mode;
  logic [5:0] item_en;
  logic [2:0] nxt_item;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] first_enabled(input logic [5:0] en,
                                               input logic [3:0] from);
    logic [2:0] r;
    r = adcs_pkg::ITEM_NONE;
    for (int i = 5; i >= 0; i--) begin
      if (en[i] && 4'(i) >= from) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [4:0] route_of(input logic [2:0]  item,
                                          input logic [15:0] dsel);
    logic [1:0] slot;
    logic [3:0] code;
    slot = 2'(item - adcs_pkg::ITEM_FIRST_DIAG);
    code = dsel[4*slot +: 4];
    if (item < adcs_pkg::ITEM_FIRST_DIAG) begin
      return adcs_pkg::ROUTE_MEASUREMENT;
    end else if (code == adcs_pkg::SRC_CURRENT) begin
      return adcs_pkg::ROUTE_INT_SOURCE + {3'h0, ~slot};
    end else if (code == adcs_pkg::SRC_ANALOG_GROUND_ALT) begin
      return adcs_pkg::ROUTE_ANALOG_GROUND;
    end else begin
      return {1'b0, code};
    end
  endfunction

  assign mode    = s_reg.ctrl[adcs_pkg::MODE_LSB +: 2];
  assign item_en = {s_reg.ctrl[adcs_pkg::DIAG_EN_LSB +: 4],
                    s_reg.ctrl[adcs_pkg::MEAS2_BIT],
                    s_reg.ctrl[adcs_pkg::MEAS1_BIT]};
  assign nxt_item = first_enabled(item_en, {1'b0, s_reg.item} + 4'h1);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next             = s_reg;
    s_next.start       = 1'b0;
    s_next.timer_start = 1'b0;

    case (s_reg.st)
      ST_OFF: begin
        // any mode other than power-down wakes the converter
        if (mode != adcs_pkg::MODE_POWERDOWN || s_reg.go) begin
          s_next.st          = ST_PWRUP;
          s_next.timer_start = 1'b1;
        end
      end
      ST_PWRUP: begin
        if (tmr_done) begin
          s_next.st      = ST_IDLE;
          s_next.powered = 1'b1;
        end
      end
      ST_IDLE: begin
        if (s_reg.go) begin
          s_next.go   = 1'b0;
          s_next.item = first_enabled(item_en, 4'h0);
          if (s_next.item != adcs_pkg::ITEM_NONE) begin
            s_next.st    = ST_WAIT;
            s_next.start = 1'b1;
            s_next.route = route_of(s_next.item, s_reg.dsel);
          end
        end else if (mode == adcs_pkg::MODE_POWERDOWN) begin
          s_next.st      = ST_OFF;
          s_next.powered = 1'b0;
        end
      end
      ST_WAIT: begin
        if (conv_done_i) begin
          if (nxt_item != adcs_pkg::ITEM_NONE) begin
            s_next.item  = nxt_item;
            s_next.start = 1'b1;
            s_next.route = route_of(nxt_item, s_reg.dsel);
          end else if (mode == adcs_pkg::MODE_CONTINUOUS) begin
            s_next.item = first_enabled(item_en, 4'h0);
            if (s_next.item == adcs_pkg::ITEM_NONE) begin
              s_next.st = ST_IDLE;
            end else begin
              s_next.start = 1'b1;
              s_next.route = route_of(s_next.item, s_reg.dsel);
            end
          end else if (mode == adcs_pkg::MODE_POWERDOWN) begin
            s_next.st      = ST_OFF;
            s_next.powered = 1'b0;
          end else begin
            s_next.st = ST_IDLE;
          end
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase

    // register port; a new start request wins over the idle clear
    if (reg_wr_i) begin
      if (reg_addr_i == adcs_pkg::ADDR_CONV_CTRL) begin
        s_next.ctrl = reg_wdata_i & adcs_pkg::CTRL_WMASK;
        if (reg_wdata_i[adcs_pkg::MODE_LSB +: 2] ==
              adcs_pkg::MODE_SINGLE ||
            reg_wdata_i[adcs_pkg::MODE_LSB +: 2] ==
              adcs_pkg::MODE_CONTINUOUS) begin
          s_next.go = 1'b1;
        end
      end else if (reg_addr_i == adcs_pkg::ADDR_DIAG_SEL) begin
        s_next.dsel = reg_wdata_i & adcs_pkg::DSEL_WMASK;
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == adcs_pkg::ADDR_CONV_CTRL) begin
        s_next.rdata = s_reg.ctrl;
      end else if (reg_addr_i == adcs_pkg::ADDR_DIAG_SEL) begin
        s_next.rdata = s_reg.dsel;
      end else begin
        s_next.rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      s_reg         <= '0;
      s_reg.st      <= ST_IDLE;
      s_reg.ctrl    <= adcs_pkg::CTRL_RESET;
      s_reg.dsel    <= adcs_pkg::DSEL_RESET;
      s_reg.item    <= adcs_pkg::ITEM_NONE;
      s_reg.powered <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  adcs_powerup_timer u_timer (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .start_i  (s_reg.timer_start),
    .busy_o   (tmr_busy),
    .done_o   (tmr_done)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_comb begin
    case (s_reg.ctrl[adcs_pkg::RATE_LSB +: 2])
      adcs_pkg::RATE_4K8: diag_rate_o = adcs_pkg::RATE_4K8;
      adcs_pkg::RATE_9K6: diag_rate_o = adcs_pkg::RATE_9K6;
      default:            diag_rate_o = adcs_pkg::RATE_SLOW;
    endcase
  end

  assign reg_rdata_o   = s_reg.rdata;
  assign conv_start_o  = s_reg.start;
  assign conv_item_o   = s_reg.item;
  assign diag_route_o  = s_reg.route;
  assign adc_powered_o = s_reg.powered;
  assign adc_busy_o    = s_reg.go || s_reg.st inside {ST_WAIT, ST_PWRUP};

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking chk_cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  a_rate_fallback: assert property (
    s_reg.ctrl[15:14] == 2'h3 |-> diag_rate_o == adcs_pkg::RATE_SLOW)
    else $error("undefined rate code not slowest");
  a_ctrl_reset: assert property (
    disable iff (1'b0) !resetn_i |=> s_reg.ctrl == '0 && s_reg.dsel == '0)
    else $error("registers not zero after reset");
  a_reserved_zero: assert property (
    reg_rd_i && reg_addr_i == 8'h3b |=> reg_rdata_o[7:2] == 6'h00)
    else $error("reserved control bits read nonzero");
  a_item_enabled: assert property (
    conv_start_o |-> item_en[conv_item_o])
    else $error("conversion started on disabled item");
  a_start_powered: assert property (
    conv_start_o |-> adc_powered_o && !tmr_busy)
    else $error("conversion started while powered down");
  a_powerdown_idle: assert property (
    s_reg.st == ST_IDLE && !s_reg.go && mode == 2'h3 |=> !adc_powered_o)
    else $error("power-down mode left converter powered");
  a_standby_power: assert property (
    s_reg.st == ST_WAIT && conv_done_i && nxt_item == 3'h6
      && mode == 2'h0 |=> adc_powered_o && !adc_busy_o)
    else $error("standby end not idle and powered");
  a_single_stop: assert property (
    s_reg.st == ST_WAIT && conv_done_i && nxt_item == 3'h6
      && mode == 2'h1 && !s_reg.go |=> !conv_start_o[*2])
    else $error("single sequence did not stop");
  a_cont_repeat: assert property (
    s_reg.st == ST_WAIT && conv_done_i && nxt_item == 3'h6
      && mode == 2'h2 && item_en != 6'h00 |=> conv_start_o)
    else $error("continuous mode did not restart");
  a_order_up: assert property (
    s_reg.st == ST_WAIT && conv_done_i && nxt_item != 3'h6
      |=> conv_start_o && conv_item_o > $past(conv_item_o))
    else $error("items not converted in ascending order");
  a_slot3_current: assert property (
    conv_start_o && conv_item_o == 3'h5 && s_reg.dsel[15:12] == 4'hf
      |-> diag_route_o == 5'h10)
    else $error("slot 3 current route wrong");
  a_slot2_current: assert property (
    conv_start_o && conv_item_o == 3'h4 && s_reg.dsel[11:8] == 4'hf
      |-> diag_route_o == 5'h11)
    else $error("slot 2 current route wrong");
  a_slot1_current: assert property (
    conv_start_o && conv_item_o == 3'h3 && s_reg.dsel[7:4] == 4'hf
      |-> diag_route_o == 5'h12)
    else $error("slot 1 current route wrong");
  a_slot0_current: assert property (
    conv_start_o && conv_item_o == 3'h2 && s_reg.dsel[3:0] == 4'hf
      |-> diag_route_o == 5'h13)
    else $error("slot 0 current route wrong");

endmodule

// *** verif/adcs_conv_model.sv ***
// Purpose: converter datapath stand-in answering start pulses
// Assumes: one conversion outstanding at a time
// Notes:   slow_i picks a long or a short conversion time

`timescale 1ns/1ps

module adcs_conv_model (
  input  wire logic mclk_i,       // core clock
  input  wire logic resetn_i,     // sync reset, active low
  input  wire logic conv_start_i, // start one conversion
  input  wire logic slow_i,       // long conversion time
  output logic      conv_done_o   // conversion finished, one cycle
);
  int cnt;

  // done never in the same cycle as the start
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      cnt <= 0;
      conv_done_o <= 1'b0;
    end else begin
      conv_done_o <= 1'b0;
      if (conv_start_i === 1'b1) begin
        cnt <= slow_i ? 20 : 2;
      end else if (cnt == 1) begin
        conv_done_o <= 1'b1;
        cnt <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// *** verif/tb_adc_conversion_sequencer.sv ***
// Purpose: self-checking bench for the converter sequencer
// Assumes: host keeps control writes legal between sequences
// Notes:   expected item order and routes come from queues

`timescale 1ns/1ps

module tb_adc_conversion_sequencer;
  logic        mclk_i      = 1'b0;
  logic        resetn_i    = 1'b0;
  logic [7:0]  reg_addr_i  = 8'h00;
  logic        reg_wr_i    = 1'b0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic        reg_rd_i    = 1'b0;
  logic        slow        = 1'b0;
  logic [15:0] reg_rdata_o;
  logic        conv_done_i;
  logic        conv_start_o;
  logic [2:0]  conv_item_o;
  logic [4:0]  diag_route_o;
  logic [1:0]  diag_rate_o;
  logic        adc_powered_o;
  logic        adc_busy_o;
  int          bad_count  = 0;
  int          num_checks = 0;
  int          seed       = 32'h5afe5cf7;
  int          idx        = 0;
  int          cyc        = 0;
  int          first      = 0;
  int          t0, r, k, n;
  logic [15:0] q_item[$];
  logic [15:0] q_route[$];
  logic [15:0] rv, ctrl;

  always #12.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cyc <= cyc + 1;

  adcs_sequencer uut (
    .mclk_i        (mclk_i),
    .resetn_i      (resetn_i),
    .reg_addr_i    (reg_addr_i),
    .reg_wr_i      (reg_wr_i),
    .reg_wdata_i   (reg_wdata_i),
    .reg_rd_i      (reg_rd_i),
    .reg_rdata_o   (reg_rdata_o),
    .conv_done_i   (conv_done_i),
    .conv_start_o  (conv_start_o),
    .conv_item_o   (conv_item_o),
    .diag_route_o  (diag_route_o),
    .diag_rate_o   (diag_rate_o),
    .adc_powered_o (adc_powered_o),
    .adc_busy_o    (adc_busy_o)
  );

  adcs_conv_model conv (
    .mclk_i       (mclk_i),
    .resetn_i     (resetn_i),
    .conv_start_i (conv_start_o),
    .slow_i       (slow),
    .conv_done_o  (conv_done_i)
  );

  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(negedge mclk_i);
    d = reg_rdata_o;
  endtask

  task wait_idle(input int lim);
    @(negedge mclk_i);
    for (n = 0; n < lim && adc_busy_o !== 1'b0; n++) @(negedge mclk_i);
    chk("busy", 16'h0000, {15'h0, adc_busy_o});
  endtask

  // ---------------------------------------------------------------
  // reference model of one sequence
  // ---------------------------------------------------------------
  function logic [15:0] exp_route(input int i, input logic [15:0] s);
    logic [3:0] code;
    if (i < 2) return 16'h001f;
    code = s[4*(i-2) +: 4];
    if (code == 4'hf) return 16'(21 - i);
    if (code == 4'he) return 16'h0000;
    return {12'h000, code};
  endfunction

  task build(input logic [15:0] c, input logic [15:0] s);
    int i;
    q_item.delete();
    q_route.delete();
    idx = 0;
    for (i = 0; i < 6; i++)
      if (i < 2 ? c[i] : c[6+i]) begin
        q_item.push_back(i[15:0]);
        q_route.push_back(exp_route(i, s));
      end
  endtask

  task setup(input logic [1:0] mode, input logic [15:0] s);
    logic [5:0] en;
    en = 6'($random(seed));
    if (en == 6'h00 || s == 16'hffff) en = 6'h3f;
    slow <= 1'($random(seed));
    ctrl = {2'h1, adcs_pkg::MODE_STANDBY, en[5:2], 6'h00, en[1:0]};
    wr(adcs_pkg::ADDR_CONV_CTRL, ctrl);
    wr(adcs_pkg::ADDR_DIAG_SEL, s);
    rd(adcs_pkg::ADDR_DIAG_SEL, rv);
    chk("source select", s, rv);
    build(ctrl, s);
    ctrl[13:12] = mode;
    wr(adcs_pkg::ADDR_CONV_CTRL, ctrl);
  endtask

  always @(negedge mclk_i)
    if (conv_start_o === 1'b1 && q_item.size() > 0) begin
      if (idx == 0) first = cyc;
      chk("item", q_item[idx % q_item.size()],
          {13'h0, conv_item_o});
      chk("route", q_route[idx % q_item.size()],
          {11'h0, diag_route_o});
      idx++;
    end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk_i);
    resetn_i <= 1'b1;
    rd(adcs_pkg::ADDR_CONV_CTRL, rv);
    chk("control reset", 16'h0000, rv);
    rd(adcs_pkg::ADDR_DIAG_SEL, rv);
    chk("select reset", 16'h0000, rv);
    chk("powered", 16'h0001, {15'h0, adc_powered_o});
    for (r = 0; r < 4; r++) begin
      wr(adcs_pkg::ADDR_CONV_CTRL, {r[1:0], 14'h0000});
      @(negedge mclk_i);
      chk("rate", r == 3 ? 16'h0 : r[15:0],
          {14'h0, diag_rate_o});
    end
    wr(adcs_pkg::ADDR_CONV_CTRL, 16'hcfff);
    wr(8'h3d, 16'hffff);
    rd(8'h3d, rv);
    chk("unmapped", 16'h0000, rv);
    rd(adcs_pkg::ADDR_CONV_CTRL, rv);
    chk("reserved", 16'hcf03, rv);
    for (k = 0; k < 6; k++) begin
      setup(adcs_pkg::MODE_SINGLE, k == 0 ? 16'hffff : 16'($random(seed)));
      wait_idle(2000);
      chk("single count", 16'(q_item.size()), 16'(idx));
    end
    // stop continuous by standby, then by power-down
    for (k = 0; k < 2; k++) begin
      setup(adcs_pkg::MODE_CONTINUOUS, 16'($random(seed)));
      for (n = 0; n < 3000 && idx < 2 * q_item.size() + 1; n++)
        @(negedge mclk_i);
      ctrl[13:12] = k ? adcs_pkg::MODE_POWERDOWN : adcs_pkg::MODE_STANDBY;
      wr(adcs_pkg::ADDR_CONV_CTRL, ctrl);
      wait_idle(3000);
      chk("tail", 16'h0000, 16'(idx % q_item.size()));
      chk("powered", 16'(1 - k), {15'h0, adc_powered_o});
    end
    build(ctrl, 16'(rv));
    rd(adcs_pkg::ADDR_DIAG_SEL, rv);
    build(ctrl, rv);
    ctrl[13:12] = adcs_pkg::MODE_SINGLE;
    t0 = cyc;
    wr(adcs_pkg::ADDR_CONV_CTRL, ctrl);
    wait_idle(6000);
    chk("wake wait", 16'h0001,
        16'(first - t0 >= adcs_pkg::POWERUP_CYCLES));
    chk("wake count", 16'(q_item.size()), 16'(idx));
    // power-down straight from idle
    ctrl[13:12] = adcs_pkg::MODE_POWERDOWN;
    wr(adcs_pkg::ADDR_CONV_CTRL, ctrl);
    repeat (2) @(negedge mclk_i);
    chk("idle power-down", 16'h0000, {15'h0, adc_powered_o});
    stop_test;
  end

  initial begin
    repeat (20000) @(posedge mclk_i);
    bad_count++;
    stop_test;
  end
endmodule
